// [core/guard_region_decoder.sv]
// Address decoder: classifies an address into a protected area and block.
// Assumes the address map constants of the guard package.
`timescale 1ns/1ps
`default_nettype none
module guard_region_decoder (
  // Address in
  input wire logic [31:0] addr,
  // Classification out
  output otp_guard_pkg::area_t area,
  output logic [3:0] blk
);
  logic [31:0] tca_ofs;
  logic [31:0] ksa_ofs;
  logic [31:0] tca_data_end;
  logic [31:0] ksa_data_end;
  always_comb begin
    tca_data_end = otp_guard_pkg::TCA_BLK_BYTES * otp_guard_pkg::NUM_BLKS;
    ksa_data_end = otp_guard_pkg::KSA_BLK_BYTES * otp_guard_pkg::NUM_BLKS;
    tca_ofs = addr - otp_guard_pkg::TCA_BASE;
    ksa_ofs = addr - otp_guard_pkg::KSA_BASE;
    area = otp_guard_pkg::AREA_OTHER;
    blk = 4'h0;
    if (addr >= otp_guard_pkg::TCA_BASE && tca_ofs < tca_data_end) begin
      area = otp_guard_pkg::AREA_TCA;
      blk = tca_ofs[otp_guard_pkg::TCA_BLK_LSB +: 4];
    end else if (addr >= otp_guard_pkg::TCA_BASE &&
                 tca_ofs < tca_data_end + otp_guard_pkg::TCA_LOCK_BYTES) begin
      area = otp_guard_pkg::AREA_TCA_LOCK;
    end else if (addr >= otp_guard_pkg::KSA_BASE && ksa_ofs < ksa_data_end) begin
      area = otp_guard_pkg::AREA_KSA;
      blk = ksa_ofs[otp_guard_pkg::KSA_BLK_LSB +: 4];
    end else if (addr >= otp_guard_pkg::KSA_BASE &&
                 ksa_ofs < ksa_data_end + otp_guard_pkg::KSA_LOCK_BYTES) begin
      area = otp_guard_pkg::AREA_KSA_LOCK;
    end else if (addr >= otp_guard_pkg::USER_BASE &&
                 addr - otp_guard_pkg::USER_BASE < otp_guard_pkg::USER_SIZE) begin
      area = otp_guard_pkg::AREA_USER;
    end else if (addr >= otp_guard_pkg::OPT_BASE &&
                 addr - otp_guard_pkg::OPT_BASE < otp_guard_pkg::OPT_SIZE) begin
      area = otp_guard_pkg::AREA_OPT;
    end else if (addr >= otp_guard_pkg::DEVREG_BASE &&
                 addr - otp_guard_pkg::DEVREG_BASE < otp_guard_pkg::DEVREG_SIZE) begin
      area = otp_guard_pkg::AREA_DEVREG;
    end
  end
endmodule : guard_region_decoder
`default_nettype wire

// [core/otp_boot_debug_security_guard.sv]
// Flash security guard: gates bus master accesses to the flash arrays.
// Assumes masters issue one-cycle requests and lock blocks are read from flash.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module otp_boot_debug_security_guard (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Nonvolatile inputs and boot request
  input wire logic [7:0] sec_byte,
  input wire otp_guard_pkg::fuse_t fuse_in,
  input wire otp_guard_pkg::boot_src_t boot_req,
  input wire logic [127:0] tca_lock_bytes,
  input wire logic [15:0] ksa_wr_lock,
  input wire logic [15:0] ksa_rd_mark,
  // Master side
  input wire otp_guard_pkg::acc_req_t req,
  output otp_guard_pkg::acc_rsp_t rsp,
  // Flash side
  output otp_guard_pkg::acc_req_t flash_req,
  // Option byte programming
  input wire logic ob_wr,
  input wire logic [7:0] ob_val,
  output logic ob_wr_ok,
  output logic ob_refused,
  output logic mass_erase,
  // Fuse programming
  output logic fuse_prog,
  output otp_guard_pkg::fuse_t fuse_prog_val,
  // Boot and debug state
  output otp_guard_pkg::boot_src_t boot_src,
  output logic boot_refused,
  output logic dbg_en
);
  // ==========================================================
  // Captured security state
  logic cap_done;
  logic [7:0] sec_byte_cap;
  otp_guard_pkg::fuse_t fuse_cap;
  otp_guard_pkg::sec_level_t level;
  otp_guard_pkg::area_t area;
  logic [3:0] blk;
  logic key_arm_r;
  logic [15:0] tca_ren_r;
  logic [31:0] reg_rdata_r;
  logic deny;
  logic fuse_prog_r;
  otp_guard_pkg::fuse_t fuse_prog_val_r;
  otp_guard_pkg::acc_rsp_t rsp_r;
  otp_guard_pkg::acc_req_t flash_req_r;
  logic mass_erase_r;
  logic ob_wr_ok_r;
  logic ob_refused_r;

  security_state_capture u_cap (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sec_byte(sec_byte),
    .fuse_in(fuse_in),
    .boot_req(boot_req),
    .cap_done(cap_done),
    .sec_byte_cap(sec_byte_cap),
    .fuse_cap(fuse_cap),
    .level(level),
    .boot_src(boot_src),
    .boot_refused(boot_refused)
  );

  guard_region_decoder u_dec (
    .addr(req.addr),
    .area(area),
    .blk(blk)
  );

  // ==========================================================
  // Helpers
  function automatic logic tca_wlocked(input logic [127:0] bytes, input logic [3:0] b);
    tca_wlocked = bytes[b * 8 +: 8] != otp_guard_pkg::LOCK_OPEN_BYTE;
  endfunction : tca_wlocked

  function automatic logic is_flash(input otp_guard_pkg::area_t a);
    is_flash = a != otp_guard_pkg::AREA_OTHER && a != otp_guard_pkg::AREA_DEVREG;
  endfunction : is_flash

  // ==========================================================
  // Access decision
  always_comb begin
    deny = 1'b0;
    // Nothing passes before the state is captured
    if (!cap_done) begin
      deny = 1'b1;
    end
    if (req.dbg && fuse_cap.dbg_off) begin
      deny = 1'b1;
    end
    if (req.dbg && level != otp_guard_pkg::LVL_NONE && is_flash(area)) begin
      deny = 1'b1;
    end
    if (level == otp_guard_pkg::LVL_LOW && area == otp_guard_pkg::AREA_USER &&
        (boot_src == otp_guard_pkg::BOOT_SRAM || boot_src == otp_guard_pkg::BOOT_LOADER)) begin
      deny = 1'b1;
    end
    if (!req.write && area == otp_guard_pkg::AREA_TCA && !tca_ren_r[blk]) begin
      deny = 1'b1;
    end
    if (!req.write && area == otp_guard_pkg::AREA_KSA && key_arm_r && ksa_rd_mark[blk]) begin
      deny = 1'b1;
    end
    if (req.write && area == otp_guard_pkg::AREA_TCA && tca_wlocked(tca_lock_bytes, blk)) begin
      deny = 1'b1;
    end
    if (req.write && area == otp_guard_pkg::AREA_KSA && ksa_wr_lock[blk]) begin
      deny = 1'b1;
    end
    if (req.write && area == otp_guard_pkg::AREA_OPT && level == otp_guard_pkg::LVL_HIGH) begin
      deny = 1'b1;
    end
  end

  // ==========================================================
  // Response and forwarding
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rsp_r <= '0;
      flash_req_r <= '0;
    end else begin
      rsp_r.ok <= req.valid && !deny;
      rsp_r.err <= req.valid && deny;
      flash_req_r <= req;
      flash_req_r.valid <= req.valid && !deny && is_flash(area);
    end
  end

  // ==========================================================
  // Option byte programming
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mass_erase_r <= 1'b0;
      ob_wr_ok_r <= 1'b0;
      ob_refused_r <= 1'b0;
    end else begin
      // Level stays at the captured value until the next reset
      ob_refused_r <= ob_wr && (level == otp_guard_pkg::LVL_HIGH || !cap_done);
      ob_wr_ok_r <= ob_wr && level != otp_guard_pkg::LVL_HIGH && cap_done;
      mass_erase_r <= ob_wr && cap_done && level == otp_guard_pkg::LVL_LOW &&
                      ob_val == otp_guard_pkg::SEC_NONE_BYTE;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      key_arm_r <= 1'b0;
    end else if (reg_wr && reg_addr == otp_guard_pkg::CTRL_OFS &&
                 reg_wdata[otp_guard_pkg::ARM_BIT]) begin
      // Set only; software cannot disarm
      key_arm_r <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tca_ren_r <= otp_guard_pkg::TCA_REN_RST;
    end else if (reg_wr && reg_addr == otp_guard_pkg::TCA_CFG_OFS) begin
      tca_ren_r <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fuse_prog_r <= 1'b0;
      fuse_prog_val_r <= '0;
    end else begin
      fuse_prog_r <= reg_wr && reg_addr == otp_guard_pkg::FUSE_OFS;
      // Programming can only add ones to the captured fuse word
      fuse_prog_val_r <= fuse_cap | otp_guard_pkg::fuse_t'(reg_wdata[3:0]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata_r <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        otp_guard_pkg::CTRL_OFS: reg_rdata_r <= {31'h0000_0000, key_arm_r};
        otp_guard_pkg::TCA_CFG_OFS: reg_rdata_r <= {16'h0000, tca_ren_r};
        otp_guard_pkg::STATUS_OFS: reg_rdata_r <= {17'h0_0000, sec_byte_cap, cap_done,
                                                   boot_refused, dbg_en, boot_src, level};
        otp_guard_pkg::FUSE_OFS: reg_rdata_r <= {28'h000_0000, fuse_cap};
        default: reg_rdata_r <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_r <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Outputs
  assign dbg_en = cap_done && !fuse_cap.dbg_off && level != otp_guard_pkg::LVL_HIGH;
  assign rsp = rsp_r;
  assign flash_req = flash_req_r;
  assign reg_rdata = reg_rdata_r;
  assign mass_erase = mass_erase_r;
  assign ob_wr_ok = ob_wr_ok_r;
  assign ob_refused = ob_refused_r;
  assign fuse_prog = fuse_prog_r;
  assign fuse_prog_val = fuse_prog_val_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_dbg_fuse_err: assert property (
    req.valid && req.dbg && fuse_cap.dbg_off |=> rsp.err && !rsp.ok && !flash_req.valid
  ) else $error("debug access passed with debug fuse set");

  a_tca_read_lock: assert property (
    req.valid && !req.write && area == otp_guard_pkg::AREA_TCA && !tca_ren_r[blk]
    |=> rsp.err && !flash_req.valid
  ) else $error("read of disabled trusted block not refused");

  a_tca_write_lock: assert property (
    req.valid && req.write && area == otp_guard_pkg::AREA_TCA &&
    tca_wlocked(tca_lock_bytes, blk) |=> rsp.err
  ) else $error("write to locked trusted block not refused");

  a_key_arm_hold: assert property (
    key_arm_r |=> key_arm_r [*3]
  ) else $error("key read lock disarmed without reset");

  a_key_read_lock: assert property (
    req.valid && !req.write && area == otp_guard_pkg::AREA_KSA && key_arm_r &&
    ksa_rd_mark[blk] |=> rsp.err
  ) else $error("read of armed key block not refused");

  a_key_write_lock: assert property (
    req.valid && req.write && area == otp_guard_pkg::AREA_KSA && ksa_wr_lock[blk]
    |=> rsp.err
  ) else $error("write to locked key block not refused");

  a_dbg_flash_deny: assert property (
    req.valid && req.dbg && level != otp_guard_pkg::LVL_NONE && is_flash(area)
    |=> rsp.err
  ) else $error("debug flash access at secured level");

  a_dbg_devreg_ok: assert property (
    cap_done && req.valid && req.dbg && !fuse_cap.dbg_off &&
    area == otp_guard_pkg::AREA_DEVREG |=> rsp.ok
  ) else $error("debug register access refused");

  a_low_boot_deny: assert property (
    req.valid && level == otp_guard_pkg::LVL_LOW && area == otp_guard_pkg::AREA_USER &&
    boot_src == otp_guard_pkg::BOOT_SRAM |=> rsp.err
  ) else $error("flash access from SRAM boot at low level");

  a_high_level: assert property (
    cap_done && sec_byte_cap == otp_guard_pkg::SEC_HIGH_BYTE |-> level == otp_guard_pkg::LVL_HIGH
    && !dbg_en
  ) else $error("high byte not decoded as high level");

  a_none_level: assert property (
    cap_done && !fuse_cap.sec_low && !fuse_cap.unique_en &&
    sec_byte_cap == otp_guard_pkg::SEC_NONE_BYTE |-> level == otp_guard_pkg::LVL_NONE
  ) else $error("open level not decoded");

  a_unique_boot: assert property (
    cap_done && fuse_cap.unique_en |-> level == otp_guard_pkg::LVL_HIGH &&
    boot_src == (fuse_cap.boot_sel ? otp_guard_pkg::BOOT_TRUSTED : otp_guard_pkg::BOOT_USER)
  ) else $error("unique boot entry not enforced");

  a_mass_erase: assert property (
    ob_wr && cap_done && level == otp_guard_pkg::LVL_LOW &&
    ob_val == otp_guard_pkg::SEC_NONE_BYTE |=> mass_erase ##1 !mass_erase || $past(ob_wr)
  ) else $error("mass erase not pulsed on return to open level");

  a_opt_high_lock: assert property (
    ob_wr && level == otp_guard_pkg::LVL_HIGH |=> ob_refused && !ob_wr_ok && !mass_erase
  ) else $error("option byte accepted at high level");

  a_fuse_no_clear: assert property (
    fuse_prog |-> (fuse_prog_val & fuse_cap) == fuse_cap
  ) else $error("fuse programming clears a set bit");

  a_early_refuse: assert property (
    req.valid && !cap_done |=> rsp.err && !rsp.ok
  ) else $error("request granted before capture");

  a_ren_open: assert property (
    cap_done && req.valid && !req.write && !req.dbg && area == otp_guard_pkg::AREA_TCA &&
    tca_ren_r[blk] |=> rsp.ok
  ) else $error("read of enabled trusted block refused");

  a_high_boot: assert property (
    cap_done && level == otp_guard_pkg::LVL_HIGH |-> boot_src != otp_guard_pkg::BOOT_SRAM &&
    boot_src != otp_guard_pkg::BOOT_LOADER
  ) else $error("SRAM or loader boot at high level");

  a_low_level: assert property (
    cap_done && !fuse_cap.unique_en && sec_byte_cap != otp_guard_pkg::SEC_HIGH_BYTE &&
    (fuse_cap.sec_low || sec_byte_cap != otp_guard_pkg::SEC_NONE_BYTE)
    |-> level == otp_guard_pkg::LVL_LOW
  ) else $error("low level not decoded");

  a_ob_open: assert property (
    ob_wr && cap_done && level != otp_guard_pkg::LVL_HIGH |=> ob_wr_ok && !ob_refused
  ) else $error("option byte refused below high level");

  a_dbg_fuse_off: assert property (
    fuse_cap.dbg_off |-> !dbg_en
  ) else $error("debug enabled with debug fuse set");

  a_fuse_pulse: assert property (
    reg_wr && reg_addr == otp_guard_pkg::FUSE_OFS |=> fuse_prog
  ) else $error("fuse write gave no programming pulse");
endmodule : otp_boot_debug_security_guard
`default_nettype wire

// [core/otp_guard_pkg.sv]
// Shared constants, types and register map of the flash security guard.
// Assumes one 50 MHz clock domain and a synchronous active-low reset.
package otp_guard_pkg;
  // ==========================================================
  // Address map (bases are plain defaults)
  localparam logic [31:0] USER_BASE = 32'h0800_0000;
  localparam logic [31:0] USER_SIZE = 32'h0080_0000;
  localparam logic [31:0] OPT_BASE = 32'h1FFF_C000;
  localparam logic [31:0] OPT_SIZE = 32'h0000_0020;
  localparam logic [31:0] TCA_BASE = 32'h1FF0_0000;
  localparam logic [31:0] TCA_BLK_BYTES = 32'h0000_2000;
  localparam logic [31:0] TCA_LOCK_BYTES = 32'h0000_0010;
  localparam logic [31:0] KSA_BASE = 32'h1FF2_0100;
  localparam logic [31:0] KSA_BLK_BYTES = 32'h0000_0020;
  localparam logic [31:0] KSA_LOCK_BYTES = 32'h0000_0020;
  localparam logic [31:0] DEVREG_BASE = 32'h4000_0000;
  localparam logic [31:0] DEVREG_SIZE = 32'h2000_0000;
  localparam int NUM_BLKS = 16;
  localparam int TCA_BLK_LSB = 13;
  localparam int KSA_BLK_LSB = 5;
  // ==========================================================
  // Option byte and lock byte values
  localparam logic [7:0] SEC_NONE_BYTE = 8'hAA;
  localparam logic [7:0] SEC_HIGH_BYTE = 8'hCC;
  localparam logic [7:0] LOCK_OPEN_BYTE = 8'hFF;
  // ==========================================================
  // Register offsets and reset values
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TCA_CFG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] FUSE_OFS = 8'h0C;
  localparam logic [15:0] TCA_REN_RST = 16'hFFFF;
  localparam int ARM_BIT = 0;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00, LVL_LOW = 2'b01, LVL_HIGH = 2'b10
  } sec_level_t;
  typedef enum logic [1:0] {
    BOOT_USER = 2'b00, BOOT_SRAM = 2'b01, BOOT_LOADER = 2'b10, BOOT_TRUSTED = 2'b11
  } boot_src_t;
  typedef enum logic [2:0] {
    AREA_OTHER = 3'b000, AREA_USER = 3'b001, AREA_OPT = 3'b010, AREA_TCA = 3'b011,
    AREA_TCA_LOCK = 3'b100, AREA_KSA = 3'b101, AREA_KSA_LOCK = 3'b110,
    AREA_DEVREG = 3'b111
  } area_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic dbg;
    logic [31:0] addr;
    logic [31:0] wdata;
  } acc_req_t;
  typedef struct packed {
    logic ok;
    logic err;
  } acc_rsp_t;
  typedef struct packed {
    logic unique_en;
    logic boot_sel;
    logic sec_low;
    logic dbg_off;
  } fuse_t;
endpackage : otp_guard_pkg

// [core/placeholder_none.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [core/security_state_capture.sv]
// Captures option byte, fuses and boot pins once after reset release.
// Assumes fuse and option byte inputs are stable once reset is released.
`timescale 1ns/1ps
`default_nettype none
module security_state_capture (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Nonvolatile values and boot request
  input wire logic [7:0] sec_byte,
  input wire otp_guard_pkg::fuse_t fuse_in,
  input wire otp_guard_pkg::boot_src_t boot_req,
  // Captured state
  output logic cap_done,
  output logic [7:0] sec_byte_cap,
  output otp_guard_pkg::fuse_t fuse_cap,
  output otp_guard_pkg::sec_level_t level,
  output otp_guard_pkg::boot_src_t boot_src,
  output logic boot_refused
);
  otp_guard_pkg::boot_src_t boot_req_r;
  // Captured one cycle after release, never from reset itself
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cap_done <= 1'b0;
      sec_byte_cap <= 8'h00;
      fuse_cap <= '0;
      boot_req_r <= otp_guard_pkg::BOOT_USER;
    end else if (!cap_done) begin
      cap_done <= 1'b1;
      sec_byte_cap <= sec_byte;
      fuse_cap <= fuse_in;
      boot_req_r <= boot_req;
    end
  end
  always_comb begin
    level = otp_guard_pkg::LVL_LOW;
    if (fuse_cap.unique_en || sec_byte_cap == otp_guard_pkg::SEC_HIGH_BYTE) begin
      level = otp_guard_pkg::LVL_HIGH;
    end else if (!fuse_cap.sec_low && sec_byte_cap == otp_guard_pkg::SEC_NONE_BYTE) begin
      level = otp_guard_pkg::LVL_NONE;
    end
    boot_src = boot_req_r;
    if (fuse_cap.unique_en) begin
      boot_src = fuse_cap.boot_sel ? otp_guard_pkg::BOOT_TRUSTED : otp_guard_pkg::BOOT_USER;
    end else if (level == otp_guard_pkg::LVL_HIGH &&
                 (boot_req_r == otp_guard_pkg::BOOT_SRAM ||
                  boot_req_r == otp_guard_pkg::BOOT_LOADER)) begin
      boot_src = otp_guard_pkg::BOOT_USER;
    end
    boot_refused = cap_done && (boot_src != boot_req_r);
  end
endmodule : security_state_capture
`default_nettype wire

// [testbench/master_model.sv]
// Bus master model: core or debug port, one access at a time.
// Assumes the guard answers each request one cycle after taking it.
`timescale 1ns/1ps
`default_nettype none
module master_model (
  // Clock
  input wire logic sys_clk,
  // Access port
  output var otp_guard_pkg::acc_req_t req,
  input wire otp_guard_pkg::acc_rsp_t rsp
);
  initial req = '0;
  // ==========================================================
  // Access: held up to the taking edge, answer taken after it
  task automatic access(input logic w, input logic g, input logic [31:0] a,
                        input logic [31:0] dat, output otp_guard_pkg::acc_rsp_t r);
    @(posedge sys_clk);
    req <= '{valid: 1'h1, write: w, dbg: g, addr: a, wdata: dat};
    @(posedge sys_clk);
    // Released lines flip so a stale request never looks live
    req <= '{valid: 1'h0, write: ~w, dbg: ~g, addr: ~a, wdata: ~dat};
    #1 r = rsp;
  endtask : access
endmodule : master_model
`default_nettype wire

// [testbench/otp_boot_debug_security_guard_test.sv]
// Bench for the flash security guard: one self-checking task per scenario.
// Assumes the guard package and master_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module otp_boot_debug_security_guard_test;
  // ==========================================================
  // Signals
  logic sys_clk;
  logic rstn;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [7:0] sec_byte;
  otp_guard_pkg::fuse_t fuse_in;
  otp_guard_pkg::boot_src_t boot_req;
  logic [127:0] tca_lock_bytes;
  logic [15:0] ksa_wr_lock;
  logic [15:0] ksa_rd_mark;
  otp_guard_pkg::acc_req_t req;
  otp_guard_pkg::acc_rsp_t rsp;
  otp_guard_pkg::acc_req_t flash_req;
  logic ob_wr;
  logic [7:0] ob_val;
  logic ob_wr_ok;
  logic ob_refused;
  logic mass_erase;
  logic fuse_prog;
  otp_guard_pkg::fuse_t fuse_prog_val;
  otp_guard_pkg::boot_src_t boot_src;
  logic boot_refused;
  logic dbg_en;
  logic [31:0] d;
  int errors = 0;
  int n_compared = 0;

  always #10 sys_clk = ~sys_clk;

  otp_boot_debug_security_guard DUT (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sec_byte(sec_byte),
    .fuse_in(fuse_in), .boot_req(boot_req), .tca_lock_bytes(tca_lock_bytes),
    .ksa_wr_lock(ksa_wr_lock), .ksa_rd_mark(ksa_rd_mark), .req(req), .rsp(rsp),
    .flash_req(flash_req), .ob_wr(ob_wr), .ob_val(ob_val), .ob_wr_ok(ob_wr_ok),
    .ob_refused(ob_refused), .mass_erase(mass_erase), .fuse_prog(fuse_prog),
    .fuse_prog_val(fuse_prog_val), .boot_src(boot_src), .boot_refused(boot_refused),
    .dbg_en(dbg_en)
  );
  master_model mm (.sys_clk(sys_clk), .req(req), .rsp(rsp));

  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // Fuses and option byte are only taken at release, so each setup needs a reset
  task automatic do_reset(input logic [7:0] sb, input logic [3:0] f, input logic [1:0] b);
    @(posedge sys_clk);
    rstn <= 1'h0;
    sec_byte <= sb;
    fuse_in <= f;
    boot_req <= otp_guard_pkg::boot_src_t'(b);
    repeat (12) @(posedge sys_clk);
    rstn <= 1'h1;
    @(posedge sys_clk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic acc(input string nm, input logic w, input logic g, input logic [31:0] a,
                     input logic e);
    otp_guard_pkg::acc_rsp_t r;
    mm.access(w, g, a, 32'h0000_5A5A, r);
    check({nm, " answer"}, 32'({r.ok, r.err}), 32'({~e, e}));
    check({nm, " flash"}, 32'(flash_req.valid), 32'(~e && a != otp_guard_pkg::DEVREG_BASE));
    check({nm, " fwd addr"}, flash_req.addr, a);
  endtask : acc

  task automatic ob_prog(input logic [7:0] v, input logic ok, input logic er);
    @(posedge sys_clk);
    ob_wr <= 1'h1;
    ob_val <= v;
    @(posedge sys_clk);
    ob_wr <= 1'h0;
    #1 check("option answer", 32'({ob_wr_ok, ob_refused}), 32'({ok, ~ok}));
    check("mass erase", 32'(mass_erase), 32'(er));
  endtask : ob_prog

  function automatic logic [31:0] tca(input int n);
    return otp_guard_pkg::TCA_BASE + 32'(n) * otp_guard_pkg::TCA_BLK_BYTES;
  endfunction : tca

  function automatic logic [31:0] ksa(input int n);
    return otp_guard_pkg::KSA_BASE + 32'(n) * otp_guard_pkg::KSA_BLK_BYTES;
  endfunction : ksa

  // ==========================================================
  // Scenarios
  task automatic t_levels;
    logic [7:0] sb [5] = '{8'hAA, 8'hAA, 8'h55, 8'hCC, 8'hAA};
    logic [3:0] fz [5] = '{4'h0, 4'h2, 4'h0, 4'h0, 4'h1};
    logic [1:0] lv [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
    logic de [5] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
    for (int i = 0; i < 5; i++) begin
      do_reset(sb[i], fz[i], 2'h0);
      rd(otp_guard_pkg::STATUS_OFS, d);
      check("level", 32'(d[1:0]), 32'(lv[i]));
      check("debug enable", 32'({d[4], dbg_en}), 32'({de[i], de[i]}));
      check("captured byte", 32'(d[14:6]), 32'({sb[i], 1'h1}));
    end
  endtask : t_levels

  task automatic t_paths;
    do_reset(8'hAA, 4'h0, 2'h0);
    acc("open debug user", 1'h0, 1'h1, otp_guard_pkg::USER_BASE, 1'h0);
    do_reset(8'h55, 4'h0, 2'h0);
    acc("low debug user", 1'h0, 1'h1, otp_guard_pkg::USER_BASE, 1'h1);
    acc("low debug trusted", 1'h0, 1'h1, tca(0), 1'h1);
    acc("low debug regs", 1'h1, 1'h1, otp_guard_pkg::DEVREG_BASE, 1'h0);
    acc("low user read", 1'h0, 1'h0, otp_guard_pkg::USER_BASE, 1'h0);
    for (int b = 1; b < 3; b++) begin
      do_reset(8'h55, 4'h0, 2'(b));
      acc("odd boot user", 1'h0, 1'h0, otp_guard_pkg::USER_BASE + 32'h10, 1'h1);
    end
    do_reset(8'hCC, 4'h0, 2'h1);
    #1 check("high boot", 32'({boot_src, boot_refused}), 32'h1);
    acc("high option write", 1'h1, 1'h0, otp_guard_pkg::OPT_BASE, 1'h1);
    acc("high debug user", 1'h0, 1'h1, otp_guard_pkg::USER_BASE, 1'h1);
    acc("high debug regs", 1'h0, 1'h1, otp_guard_pkg::DEVREG_BASE, 1'h0);
    acc("high user read", 1'h0, 1'h0, otp_guard_pkg::USER_BASE, 1'h0);
  endtask : t_paths

  task automatic t_trusted;
    do_reset(8'hAA, 4'h0, 2'h0);
    tca_lock_bytes <= {{10{8'hFF}}, 8'h3C, {5{8'hFF}}};
    rd(otp_guard_pkg::TCA_CFG_OFS, d);
    check("read enable reset", d, 32'h0000_FFFF);
    wr(otp_guard_pkg::TCA_CFG_OFS, 32'h0000_7FDF);
    acc("hidden block read", 1'h0, 1'h0, tca(5), 1'h1);
    acc("last block read", 1'h0, 1'h0, tca(15), 1'h1);
    acc("open block read", 1'h0, 1'h0, tca(4), 1'h0);
    acc("locked block write", 1'h1, 1'h0, tca(5) + 32'h1FFC, 1'h1);
    acc("open block write", 1'h1, 1'h0, tca(6), 1'h0);
    wr(otp_guard_pkg::TCA_CFG_OFS, 32'h0000_FFFF);
    acc("reopened read", 1'h0, 1'h0, tca(5), 1'h0);
    acc("still write locked", 1'h1, 1'h0, tca(5), 1'h1);
    tca_lock_bytes <= '1;
  endtask : t_trusted

  task automatic t_keys;
    ksa_rd_mark <= 16'h0004;
    ksa_wr_lock <= 16'h8000;
    acc("unarmed key read", 1'h0, 1'h0, ksa(2), 1'h0);
    wr(otp_guard_pkg::CTRL_OFS, 32'h0000_0001);
    rd(otp_guard_pkg::CTRL_OFS, d);
    check("arm bit", d, 32'h0000_0001);
    acc("armed key read", 1'h0, 1'h0, ksa(2) + 32'h1C, 1'h1);
    acc("unmarked key read", 1'h0, 1'h0, ksa(3), 1'h0);
    wr(otp_guard_pkg::CTRL_OFS, 32'h0000_0000);
    acc("arm held", 1'h0, 1'h0, ksa(2), 1'h1);
    acc("locked key write", 1'h1, 1'h0, ksa(15), 1'h1);
    acc("open key write", 1'h1, 1'h0, ksa(14), 1'h0);
    rd(8'hF0, d);
    check("unmapped read", d, 32'h0000_0000);
    do_reset(8'hAA, 4'h0, 2'h0);
    rd(otp_guard_pkg::CTRL_OFS, d);
    check("arm after reset", d, 32'h0000_0000);
    acc("key read after reset", 1'h0, 1'h0, ksa(2), 1'h0);
  endtask : t_keys

  task automatic t_boot;
    do_reset(8'hAA, 4'h8, 2'h1);
    rd(otp_guard_pkg::STATUS_OFS, d);
    check("flash entry status", 32'(d[5:0]), 32'h0000_0022);
    check("flash entry pins", 32'({boot_src, boot_refused}), 32'h1);
    acc("flash entry user read", 1'h0, 1'h0, otp_guard_pkg::USER_BASE, 1'h0);
    do_reset(8'hAA, 4'hC, 2'h0);
    rd(otp_guard_pkg::STATUS_OFS, d);
    check("trusted entry status", 32'(d[5:0]), 32'h0000_002E);
    wr(otp_guard_pkg::FUSE_OFS, 32'h0000_0000);
    #1 check("entry fuse kept", 32'({fuse_prog, fuse_prog_val}), 32'h1C);
    do_reset(8'hAA, 4'h1, 2'h0);
    acc("fused debug regs", 1'h0, 1'h1, otp_guard_pkg::DEVREG_BASE, 1'h1);
    wr(otp_guard_pkg::FUSE_OFS, 32'h0000_0004);
    #1 check("debug fuse kept", 32'({fuse_prog, fuse_prog_val}), 32'h15);
  endtask : t_boot

  task automatic t_option;
    do_reset(8'h55, 4'h0, 2'h0);
    ob_prog(8'hAA, 1'h1, 1'h1);
    ob_prog(8'h55, 1'h1, 1'h0);
    do_reset(8'hAA, 4'h0, 2'h0);
    ob_prog(8'hAA, 1'h1, 1'h0);
    do_reset(8'hCC, 4'h0, 2'h0);
    ob_prog(8'hAA, 1'h0, 1'h0);
  endtask : t_option

  // ==========================================================
  // Main sequence
  initial begin
    sys_clk = 1'h0;
    rstn = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    sec_byte = 8'hAA;
    fuse_in = 4'h0;
    boot_req = otp_guard_pkg::BOOT_USER;
    tca_lock_bytes = '1;
    ksa_wr_lock = 16'h0000;
    ksa_rd_mark = 16'h0000;
    ob_wr = 1'h0;
    ob_val = 8'h00;
    t_levels();
    t_paths();
    t_trusted();
    t_keys();
    t_boot();
    t_option();
    test_done();
  end

  // Whole run is about 350 cycles; this is 10000 cycles, over 25 times that
  initial begin
    #200_000;
    errors++;
    test_done();
  end
endmodule : otp_boot_debug_security_guard_test
`default_nettype wire
